// *** shared/aph_map.svh ***
// Address map, field positions, reset values and counts of the absolute position block
//
// Operation
// - Turns word is multiturn count, else zero
// - Pulse mode: in-turn count 0 to 1279999
// - User mode: position word is signed user count
// - 16-bit display selector taking codes 0 to 127
// - Code 03 shows raw feedback pulse count
// - Code 18 shows index-relative count, -4999..+5000
// - Index pulses spaced 10000 counts apart
// - Codes 19-22 show mapped target parameters
// - Codes 23-26 show selected status monitors
// - Code 38 shows battery voltage in 0.1 V
// - Function 0x1D input is level absolute enable
// - Enable turns input four, outputs two/three over
// - Enable locks input four function setting
// - Both request edges act, only while enabled
// - Clear rising edge zeroes pulses, loads preset
// - Clear ignored unless absolute enable is on
// - Clear assigned through ordinary input functions
// - Ready high when prepared, low once fetched
// - Data bit held valid while ready high
// - Unit config bit 1 picks pulses or user units
`ifndef APH_MAP_SVH
`define APH_MAP_SVH

`define APH_ADDR_W 12
`define APH_A_DISP_SEL 12'h004
`define APH_A_DISP_VAL 12'h006
`define APH_A_MON_SEL0 12'h022
`define APH_A_MAP_TGT0 12'h046
`define APH_A_TURNS 12'h066
`define APH_A_IN_TURN 12'h068
`define APH_A_IN_FN0 12'h214
`define APH_A_UNIT_CFG 12'h28c
`define APH_A_HOME_PRE 12'h602

`define APH_NUM_IN 4
`define APH_IN_FOUR 2'h3
`define APH_FN_ABS_EN 8'h1d
`define APH_FN_ABS_CLR 8'h1f
`define APH_UNIT_COMM_BIT 1
`define APH_UNIT_CFG_W 3

`define APH_IN_TURN_MAX 21'h1387ff
`define APH_IDX_MAX 14'h270f
`define APH_IDX_HALF 14'h1388
`define APH_IDX_SPAN32 32'h00002710
`define APH_SEL_MAX32 32'h0000007f

`define APH_CODE_FB 7'h03
`define APH_CODE_IDX 7'h12
`define APH_CODE_MAP_LO 7'h13
`define APH_CODE_MAP_HI 7'h16
`define APH_CODE_MON_LO 7'h17
`define APH_CODE_MON_HI 7'h1a
`define APH_CODE_BATT 7'h26

`define APH_RST_WORD 32'h00000000
`define APH_RST_SEL 16'h0000
`define APH_RST_UNIT 3'h0
`define APH_RST_FN 8'h00

`endif

// *** shared/aph_pkg.sv ***
// Types shared by the absolute position block
package aph_pkg;
   typedef enum logic [1:0] {
      APH_ST_OFF = 2'b00,
      APH_ST_WAIT = 2'b01,
      APH_ST_SHOW = 2'b10
   } aph_state_t;
   typedef logic [31:0] aph_word_t;
endpackage

// *** rtl/aph_sync_edge.sv ***
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module aph_sync_edge (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Edges seen only past the second stage
   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

// *** rtl/aph_top.sv ***
// Absolute position words, status display and bit-serial readout handshake
`timescale 1ns/1ps
`default_nettype none
`include "aph_map.svh"
module aph_top (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [3:0] di_pin,
   input wire logic gen_out_two,
   input wire logic gen_out_three,
   output logic output_two,
   output logic output_three,
   output logic [3:0] di_level,
   output logic absolute_mode_enable,
   input wire logic enc_up,
   input wire logic enc_dn,
   input wire logic enc_index,
   input wire logic puu_up,
   input wire logic puu_dn,
   input wire logic [7:0] batt_tenths,
   input wire logic [31:0] ext_value,
   output logic [6:0] ext_code,
   output logic [31:0] disp_value,
   input wire logic [11:0] par_addr,
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [31:0] par_wdata,
   output logic [31:0] par_rdata,
   output logic par_ack,
   output logic par_err
);
   localparam int NUM_IN = `APH_NUM_IN;

   aph_pkg::aph_state_t state_r;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] fall;
   logic abs_en_r;
   logic clr_evt;
   logic req_rise;
   logic req_fall;
   logic [20:0] in_turn_r;
   logic [15:0] turns_r;
   logic [31:0] puu_r;
   logic [31:0] fb_r;
   logic [13:0] idx_r;
   logic [31:0] idx_signed;
   logic [15:0] disp_sel_r;
   logic [`APH_UNIT_CFG_W-1:0] unit_r;
   logic [31:0] home_r;
   logic [7:0] in_fn_r [NUM_IN];
   logic [11:0] map_tgt_r [NUM_IN];
   logic [6:0] mon_sel_r [NUM_IN];
   logic [31:0] disp_nxt;
   logic [31:0] disp_val_r;
   logic [6:0] eff_code;
   logic [31:0] turns_word;
   logic [31:0] pos_word;
   logic [63:0] snap;
   logic [63:0] shift_r;
   logic [5:0] bit_cnt_r;
   logic data_r;
   logic out_two_r;
   logic out_three_r;
   logic [3:0] di_level_r;
   logic [32:0] rd_res;
   logic wr_ok;
   logic [2:0] fn_h;
   logic [2:0] map_h;
   logic [2:0] mon_h;
   logic [31:0] par_rdata_r;
   logic par_ack_r;
   logic par_err_r;

   // {hit, index} for a bank of four registers two addresses apart
   function automatic logic [2:0] bank_hit(input logic [11:0] addr, input logic [11:0] base);
      logic [11:0] diff;
      diff = addr - base;
      bank_hit = {(diff[11:3] == 9'h000) && !diff[0], diff[2:1]};
   endfunction

   // Inputs carrying a function code; input four drops out while overridden
   function automatic logic [3:0] fn_mask(input logic [7:0] code, input logic ovr);
      integer i;
      fn_mask = 4'h0;
      for (i = 0; i < NUM_IN; i++)
      begin
         fn_mask[i] = (in_fn_r[i] == code) && !(ovr && (i == 3));
      end
   endfunction

   // {hit, data} of a parameter read, shared by the port and the mapping display
   function automatic logic [32:0] param_read(input logic [11:0] addr);
      logic [2:0] h_fn;
      logic [2:0] h_map;
      logic [2:0] h_mon;
      h_fn = bank_hit(addr, `APH_A_IN_FN0);
      h_map = bank_hit(addr, `APH_A_MAP_TGT0);
      h_mon = bank_hit(addr, `APH_A_MON_SEL0);
      if (addr == `APH_A_TURNS)
         param_read = {1'b1, turns_word};
      else if (addr == `APH_A_IN_TURN)
         param_read = {1'b1, pos_word};
      else if (addr == `APH_A_DISP_SEL)
         param_read = {1'b1, 16'h0000, disp_sel_r};
      else if (addr == `APH_A_DISP_VAL)
         param_read = {1'b1, disp_val_r};
      else if (addr == `APH_A_UNIT_CFG)
         param_read = {1'b1, 29'h00000000, unit_r};
      else if (addr == `APH_A_HOME_PRE)
         param_read = {1'b1, home_r};
      else if (h_fn[2])
         param_read = {1'b1, 24'h000000, in_fn_r[h_fn[1:0]]};
      else if (h_map[2])
         param_read = {1'b1, 20'h00000, map_tgt_r[h_map[1:0]]};
      else if (h_mon[2])
         param_read = {1'b1, 25'h0000000, mon_sel_r[h_mon[1:0]]};
      else
         param_read = {1'b0, `APH_RST_WORD};
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_IN; g++)
      begin : g_in
         aph_sync_edge u_sync (
            .clock(clock),
            .arst_n(arst_n),
            .pin_in(di_pin[g]),
            .level(lvl[g]),
            .rise(rise[g]),
            .fall(fall[g])
         );

         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               in_fn_r[g] <= `APH_RST_FN;
            else if (par_wr && wr_ok && fn_h[2] && (fn_h[1:0] == 2'(g)))
               in_fn_r[g] <= par_wdata[7:0];
         end

         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               map_tgt_r[g] <= 12'h000;
            else if (par_wr && wr_ok && map_h[2] && (map_h[1:0] == 2'(g)))
               map_tgt_r[g] <= par_wdata[11:0];
         end

         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               mon_sel_r[g] <= 7'h00;
            else if (par_wr && wr_ok && mon_h[2] && (mon_h[1:0] == 2'(g)))
               mon_sel_r[g] <= par_wdata[6:0];
         end
      end
   endgenerate

   // Enable sampled as a registered level so the input-four override has no loop
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         abs_en_r <= 1'b0;
      else
         abs_en_r <= |(fn_mask(`APH_FN_ABS_EN, abs_en_r) & lvl);
   end

   assign clr_evt = abs_en_r && |(fn_mask(`APH_FN_ABS_CLR, abs_en_r) & rise);
   assign req_rise = abs_en_r && rise[`APH_IN_FOUR];
   assign req_fall = abs_en_r && fall[`APH_IN_FOUR];

   assign turns_word = unit_r[`APH_UNIT_COMM_BIT] ? {{16{turns_r[15]}}, turns_r} : `APH_RST_WORD;
   assign pos_word = unit_r[`APH_UNIT_COMM_BIT] ? {11'h000, in_turn_r} : puu_r;
   assign snap = {turns_word, pos_word};

   // Encoder position inside the turn, with turn carry; clear wins over motion
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         in_turn_r <= 21'h000000;
         turns_r <= 16'h0000;
      end
      else if (clr_evt)
      begin
         in_turn_r <= 21'h000000;
         turns_r <= 16'h0000;
      end
      else if (enc_up && !enc_dn)
      begin
         if (in_turn_r == `APH_IN_TURN_MAX)
         begin
            in_turn_r <= 21'h000000;
            turns_r <= turns_r + 16'h0001;
         end
         else
            in_turn_r <= in_turn_r + 21'h000001;
      end
      else if (enc_dn && !enc_up)
      begin
         if (in_turn_r == 21'h000000)
         begin
            in_turn_r <= `APH_IN_TURN_MAX;
            turns_r <= turns_r - 16'h0001;
         end
         else
            in_turn_r <= in_turn_r - 21'h000001;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         puu_r <= `APH_RST_WORD;
      else if (clr_evt)
         puu_r <= home_r;
      else if (puu_up && !puu_dn)
         puu_r <= puu_r + 32'h00000001;
      else if (puu_dn && !puu_up)
         puu_r <= puu_r - 32'h00000001;
   end

   // Raw feedback count, never scaled by the gear ratio
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         fb_r <= `APH_RST_WORD;
      else if (enc_up && !enc_dn)
         fb_r <= fb_r + 32'h00000001;
      else if (enc_dn && !enc_up)
         fb_r <= fb_r - 32'h00000001;
   end

   // Index counter; index pulse marks index-relative zero, ahead of any step
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         idx_r <= 14'h0000;
      else if (enc_index)
         idx_r <= 14'h0000;
      else if (enc_up && !enc_dn)
         idx_r <= (idx_r == `APH_IDX_MAX) ? 14'h0000 : idx_r + 14'h0001;
      else if (enc_dn && !enc_up)
         idx_r <= (idx_r == 14'h0000) ? `APH_IDX_MAX : idx_r - 14'h0001;
   end

   assign idx_signed = (idx_r > `APH_IDX_HALF) ? {18'h00000, idx_r} - `APH_IDX_SPAN32 :
      {18'h00000, idx_r};

   // Monitor codes resolve to the code they select before the value is chosen
   always_comb
   begin
      logic [6:0] sel;
      logic [6:0] off;
      logic [32:0] map_rd;
      sel = disp_sel_r[6:0];
      off = 7'h00;
      map_rd = 33'h000000000;
      eff_code = sel;
      if ((sel >= `APH_CODE_MON_LO) && (sel <= `APH_CODE_MON_HI))
      begin
         off = sel - `APH_CODE_MON_LO;
         eff_code = mon_sel_r[off[1:0]];
      end
      if ((sel >= `APH_CODE_MAP_LO) && (sel <= `APH_CODE_MAP_HI))
      begin
         off = sel - `APH_CODE_MAP_LO;
         map_rd = param_read(map_tgt_r[off[1:0]]);
         disp_nxt = map_rd[31:0];
      end
      else if (eff_code == `APH_CODE_FB)
         disp_nxt = fb_r;
      else if (eff_code == `APH_CODE_IDX)
         disp_nxt = idx_signed;
      else if (eff_code == `APH_CODE_BATT)
         disp_nxt = {24'h000000, batt_tenths};
      else
         disp_nxt = ext_value;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         disp_val_r <= `APH_RST_WORD;
      else
         disp_val_r <= disp_nxt;
   end

   // Parameter access decode
   always_comb
   begin
      fn_h = bank_hit(par_addr, `APH_A_IN_FN0);
      map_h = bank_hit(par_addr, `APH_A_MAP_TGT0);
      mon_h = bank_hit(par_addr, `APH_A_MON_SEL0);
      rd_res = param_read(par_addr);
      if (par_addr == `APH_A_DISP_SEL)
         wr_ok = (par_wdata <= `APH_SEL_MAX32);
      else if (par_addr == `APH_A_UNIT_CFG)
         wr_ok = 1'b1;
      else if (par_addr == `APH_A_HOME_PRE)
         wr_ok = 1'b1;
      else if (fn_h[2])
         wr_ok = !(abs_en_r && (fn_h[1:0] == `APH_IN_FOUR));
      else if (map_h[2])
         wr_ok = 1'b1;
      else if (mon_h[2])
         wr_ok = (par_wdata <= `APH_SEL_MAX32);
      else
         wr_ok = 1'b0;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         disp_sel_r <= `APH_RST_SEL;
         unit_r <= `APH_RST_UNIT;
         home_r <= `APH_RST_WORD;
      end
      else if (par_wr && wr_ok)
      begin
         if (par_addr == `APH_A_DISP_SEL)
            disp_sel_r <= par_wdata[15:0];
         if (par_addr == `APH_A_UNIT_CFG)
            unit_r <= par_wdata[`APH_UNIT_CFG_W-1:0];
         if (par_addr == `APH_A_HOME_PRE)
            home_r <= par_wdata;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         par_rdata_r <= `APH_RST_WORD;
         par_ack_r <= 1'b0;
         par_err_r <= 1'b0;
      end
      else
      begin
         if (par_rd)
            par_rdata_r <= rd_res[31:0];
         par_ack_r <= par_wr | par_rd;
         par_err_r <= (par_wr && !wr_ok) || (par_rd && !rd_res[32]);
      end
   end

   // Readout handshake; host drops request to ask, raises it once read
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= aph_pkg::APH_ST_OFF;
         bit_cnt_r <= 6'h00;
         shift_r <= 64'h0000000000000000;
         data_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            aph_pkg::APH_ST_OFF:
            begin
               data_r <= 1'b0;
               bit_cnt_r <= 6'h00;
               if (abs_en_r)
                  state_r <= aph_pkg::APH_ST_WAIT;
            end
            aph_pkg::APH_ST_WAIT:
            begin
               if (!abs_en_r)
                  state_r <= aph_pkg::APH_ST_OFF;
               else if (req_fall)
               begin
                  if (bit_cnt_r == 6'h00)
                  begin
                     data_r <= snap[63];
                     shift_r <= {snap[62:0], 1'b0};
                  end
                  else
                  begin
                     data_r <= shift_r[63];
                     shift_r <= {shift_r[62:0], 1'b0};
                  end
                  state_r <= aph_pkg::APH_ST_SHOW;
               end
            end
            aph_pkg::APH_ST_SHOW:
            begin
               if (!abs_en_r)
                  state_r <= aph_pkg::APH_ST_OFF;
               else if (req_rise)
               begin
                  bit_cnt_r <= bit_cnt_r + 6'h01;
                  state_r <= aph_pkg::APH_ST_WAIT;
               end
            end
            default:
               state_r <= aph_pkg::APH_ST_OFF;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         out_two_r <= 1'b0;
         out_three_r <= 1'b0;
         di_level_r <= 4'h0;
      end
      else
      begin
         out_two_r <= abs_en_r ? (state_r == aph_pkg::APH_ST_SHOW) : gen_out_two;
         out_three_r <= abs_en_r ? data_r : gen_out_three;
         di_level_r <= lvl & ~{abs_en_r, 3'h0};
      end
   end

   assign output_two = out_two_r;
   assign output_three = out_three_r;
   assign di_level = di_level_r;
   assign absolute_mode_enable = abs_en_r;
   assign disp_value = disp_val_r;
   assign ext_code = eff_code;
   assign par_rdata = par_rdata_r;
   assign par_ack = par_ack_r;
   assign par_err = par_err_r;

   sequence s_ask;
      (state_r == aph_pkg::APH_ST_WAIT) && req_fall;
   endsequence
   sequence s_show;
      (state_r == aph_pkg::APH_ST_SHOW) ##1 (out_two_r && (out_three_r == $past(data_r)));
   endsequence

   a_turns_user_zero: assert property (@(posedge clock) disable iff (!arst_n)
      (par_rd && (par_addr == `APH_A_TURNS) && !unit_r[1]) |=> (par_rdata_r == 32'h00000000))
      else $error("turns word not zero in user unit mode");
   a_in_turn_range: assert property (@(posedge clock) disable iff (!arst_n)
      in_turn_r <= `APH_IN_TURN_MAX)
      else $error("in-turn count out of range");
   a_user_pos_word: assert property (@(posedge clock) disable iff (!arst_n)
      (par_rd && (par_addr == `APH_A_IN_TURN) && !unit_r[1]) |=> (par_rdata_r == $past(puu_r)))
      else $error("position word not user count");
   a_sel_range: assert property (@(posedge clock) disable iff (!arst_n)
      disp_sel_r <= 16'h007f)
      else $error("display selector above 127");
   a_fb_display: assert property (@(posedge clock) disable iff (!arst_n)
      (disp_sel_r == 16'h0003) |=> (disp_val_r == $past(fb_r)))
      else $error("code 03 not raw feedback");
   a_idx_wrap: assert property (@(posedge clock) disable iff (!arst_n)
      (enc_up && !enc_dn && !enc_index && (idx_r == 14'h270f)) |=> (idx_r == 14'h0000))
      else $error("index counter not wrapping at 10000");
   a_fn_locked: assert property (@(posedge clock) disable iff (!arst_n)
      (par_wr && abs_en_r && (par_addr == 12'h21a)) |=> $stable(in_fn_r[3]) && par_err_r)
      else $error("input four setting changed under enable");
   a_clear_loads: assert property (@(posedge clock) disable iff (!arst_n)
      clr_evt |=> (in_turn_r == 21'h000000) && (puu_r == $past(home_r)))
      else $error("clear did not zero count and load preset");
   a_off_idle: assert property (@(posedge clock) disable iff (!arst_n)
      (!abs_en_r && (state_r == aph_pkg::APH_ST_OFF)) |=> (state_r != aph_pkg::APH_ST_SHOW))
      else $error("handshake acted while disabled");
   a_bit_ready: assert property (@(posedge clock) disable iff (!arst_n)
      (s_ask ##1 abs_en_r) |-> s_show)
      else $error("ready not raised with bit after request");
   a_data_hold: assert property (@(posedge clock) disable iff (!arst_n)
      (abs_en_r && out_two_r && $past(out_two_r)) |-> $stable(out_three_r))
      else $error("data changed while ready high");
endmodule
`default_nettype wire

// *** verification/aph_host.sv ***
// Host controller model reading the position frame
`timescale 1ns/1ps
`default_nettype none
module aph_host (
   input wire logic clock,
   input wire logic ready,
   input wire logic data_bit,
   output var logic request
);
   initial request = 1'b1;
   // Bounded wait; a stuck drive clears ok
   task automatic wait_rdy(input logic lvl, inout bit ok);
      int n;
      n = 0;
      while (ready !== lvl && n < 40)
      begin
         @(negedge clock);
         n++;
      end
      if (ready !== lvl)
         ok = 0;
   endtask
   task automatic read_frame(output logic [63:0] f, output bit ok);
      ok = 1;
      f = '0;
      for (int i = 0; i < 64; i++)
      begin
         @(negedge clock);
         request = 1'b0;
         wait_rdy(1'b1, ok);
         f = {f[62:0], data_bit};
         request = 1'b1;
         wait_rdy(1'b0, ok);
      end
   endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the absolute position block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, arst_n, req, go2, go3, o2, o3, abs_en, wr, rd, ack, err;
   logic [2:0] dil;
   logic [3:0] dl;
   logic [6:0] code;
   logic [4:0] mv;
   logic [11:0] adr;
   logic [31:0] wd, rdat, disp;
   int mismatches = 0;
   int total_checks = 0;
   aph_top dut (.clock(clock), .arst_n(arst_n), .di_pin({req, dil}), .gen_out_two(go2),
      .gen_out_three(go3), .output_two(o2), .output_three(o3), .di_level(dl),
      .absolute_mode_enable(abs_en), .enc_up(mv[0]), .enc_dn(mv[1]), .enc_index(mv[2]),
      .puu_up(mv[3]), .puu_dn(mv[4]), .batt_tenths(8'h24), .ext_value(32'h0),
      .ext_code(code), .disp_value(disp), .par_addr(adr), .par_wr(wr), .par_rd(rd),
      .par_wdata(wd), .par_rdata(rdat), .par_ack(ack), .par_err(err));
   aph_host host (.clock(clock), .ready(o2), .data_bit(o3), .request(req));
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Read data judged only on an accepted read
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic e, input logic [31:0] q);
      @(negedge clock);
      wr = w;
      rd = ~w;
      adr = a;
      wd = d;
      @(negedge clock);
      wr = 1'b0;
      rd = 1'b0;
      // Ack stands one cycle only, so judge it right after the taking edge
      chk("ack", ack, 1'b1);
      chk("err", err, e);
      if (!w && !e)
         chk("rdata", rdat, q);
   endtask
   // Gaps between pulses so every step is a separate event
   task automatic steps(input logic [4:0] m, input int n);
      repeat (n)
      begin
         @(negedge clock);
         mv = m;
         @(negedge clock);
         mv = 5'h0;
      end
      wait_n(2);
   endtask
   task automatic t_regs();
      acc(0, 12'h068, 0, 0, 32'h0);
      acc(0, 12'h004, 0, 0, 32'h0);
      acc(1, 12'h068, 5, 1, 0);
      acc(0, 12'h0fe, 0, 1, 0);
   endtask
   task automatic t_display();
      acc(1, 12'h004, 32'h7f, 0, 0);
      acc(1, 12'h004, 32'h80, 1, 0);
      acc(0, 12'h004, 0, 0, 32'h7f);
      acc(1, 12'h004, 32'h26, 0, 0);
      wait_n(2);
      chk("battery", disp, 32'h24);
      acc(1, 12'h602, 32'h5a, 0, 0);
      acc(1, 12'h046, 32'h602, 0, 0);
      acc(1, 12'h004, 32'h13, 0, 0);
      wait_n(2);
      chk("mapped", disp, 32'h5a);
      acc(1, 12'h024, 32'h80, 1, 0);
      acc(1, 12'h022, 32'h26, 0, 0);
      acc(1, 12'h004, 32'h17, 0, 0);
      wait_n(2);
      chk("monitor", disp, 32'h24);
      chk("code", code, 7'h26);
   endtask
   task automatic t_wrap();
      acc(1, 12'h28c, 32'h2, 0, 0);
      steps(5'h02, 1);
      acc(0, 12'h068, 0, 0, 32'h1387ff);
      acc(0, 12'h066, 0, 0, 32'hffffffff);
      acc(1, 12'h216, 32'h1f, 0, 0);
      dil[1] = 1'b1;
      wait_n(5);
      acc(0, 12'h068, 0, 0, 32'h1387ff);
      dil[1] = 1'b0;
   endtask
   task automatic t_frame();
      logic [63:0] f;
      bit ok;
      go2 = 1'b1;
      go3 = 1'b1;
      wait_n(3);
      chk("out two", o2, 1'b1);
      chk("out three", o3, 1'b1);
      chk("di level", dl, 4'h8);
      acc(1, 12'h214, 32'h1d, 0, 0);
      dil[0] = 1'b1;
      wait_n(5);
      chk("enable", abs_en, 1'b1);
      chk("ready idle", o2, 1'b0);
      chk("di level", dl, 4'h1);
      acc(1, 12'h21a, 32'h1f, 1, 0);
      host.read_frame(f, ok);
      chk("handshake", ok, 1'b1);
      chk("frame", f, {32'hffffffff, 32'h001387ff});
   endtask
   task automatic t_clear();
      steps(5'h01, 5);
      acc(0, 12'h068, 0, 0, 32'h4);
      acc(1, 12'h004, 32'h3, 0, 0);
      wait_n(2);
      chk("feedback", disp, 32'h4);
      dil[1] = 1'b1;
      wait_n(5);
      acc(0, 12'h068, 0, 0, 32'h0);
      acc(1, 12'h602, 32'h1, 0, 0);
      acc(1, 12'h28c, 32'h0, 0, 0);
      dil[1] = 1'b0;
      wait_n(5);
      dil[1] = 1'b1;
      wait_n(5);
      steps(5'h10, 3);
      steps(5'h02, 1);
      acc(0, 12'h068, 0, 0, 32'hfffffffe);
      acc(0, 12'h066, 0, 0, 32'h0);
   endtask
   task automatic t_index();
      acc(1, 12'h004, 32'h12, 0, 0);
      steps(5'h04, 1);
      steps(5'h02, 2);
      chk("index", disp, 32'hfffffffe);
   endtask
   initial
   begin
      {dil, go2, go3, mv, wr, rd, adr, wd} = '0;
      arst_n = 1'b0;
      wait_n(2);
      arst_n = 1'b1;
      t_regs();
      t_display();
      t_wrap();
      t_frame();
      t_clear();
      t_index();
      tally_and_finish();
   end
endmodule
`default_nettype wire
